// ### inc/cfg_word_pkg.sv
// Purpose: Constants shared by the converter setup word decoder.
// Assumes: A 14-bit setup word shifted in MSB first over a serial link.
// Notes: Field positions, codes, reset values and counts live here.
// Contract
// - Pairing 00x gives bipolar differential, bit 10 ignored.
// - Pairing 010 bipolar vs common; 011 temperature.
// - Pairing 10x gives unipolar differential, LSB ignored.
// - Pairing 110 common ground sense; 111 ground.
// - Bandwidth bit 0 quarter bandwidth, 1 full.
// - Reference 001 internal 4.096V, sensor on; avoid unused.
// - Reference 010 external, 011 buffered; sensor on.
// - Reference 110 external, 111 buffered; sensor off.
// - Internal reference enabled keeps temperature sensor powered.
// - Sequencer 00 off; 01 keeps running sequence.
// - Sequencer 10 scans channels then one temperature.
// - Sequencer 11 scans channels then wraps to zero.
// - Readback bit 0 appends word after result.
// - Bit 13 low keeps current setup word.
// - Word MSB first, first 14 rising clocks.
// - New word applies only at conversion end.
// - Two conversions with data high load all ones.
package cfg_word_pkg;
  localparam int unsigned WORD_W = 14;
  localparam int unsigned CNT_W = 4;
  localparam logic [3:0] WORD_BITS = 4'he;
  localparam logic [13:0] WORD_RESET = 14'h3fff;
  localparam logic [1:0] SCAN_RESET = 2'h3;
  localparam int unsigned UPDATE_BIT = 13;
  localparam int unsigned PAIR_HI = 12;
  localparam int unsigned PAIR_LO = 10;
  localparam int unsigned CHAN_HI = 9;
  localparam int unsigned CHAN_LO = 7;
  localparam int unsigned BW_BIT = 6;
  localparam int unsigned REF_HI = 5;
  localparam int unsigned REF_LO = 3;
  localparam int unsigned SEQ_HI = 2;
  localparam int unsigned SEQ_LO = 1;
  localparam int unsigned READBACK_BIT = 0;
  localparam logic [2:0] PAIR_TEMP = 3'h3;
  localparam logic [2:0] PAIR_SE_COM_GND = 3'h6;
  localparam logic [2:0] REF_INTERNAL = 3'h1;
  localparam logic [2:0] REF_EXT_SENSOR = 3'h2;
  localparam logic [2:0] REF_BUF_SENSOR = 3'h3;
  localparam logic [2:0] REF_EXT_QUIET = 3'h6;
  localparam logic [2:0] REF_BUF_QUIET = 3'h7;
  localparam logic [1:0] SEQ_OFF = 2'h0;
  localparam logic [1:0] SEQ_KEEP = 2'h1;
  localparam logic [1:0] SEQ_SCAN_TEMP = 2'h2;
  localparam logic [1:0] SEQ_SCAN = 2'h3;
endpackage

// ### logic/seq_stepper.sv
// Purpose: Steps the conversion channel for the channel sequencer.
// Assumes: i_step pulses once per end of conversion.
// Notes: Mode 00 parks at channel 0; modes 1x scan up to i_last.
module seq_stepper #(
  parameter int unsigned CH_W = 3
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_step,
  input wire logic i_restart,
  input wire logic [1:0] i_mode,
  input wire logic [CH_W-1:0] i_last,
  output logic [CH_W-1:0] o_channel,
  output logic o_temp_slot
);
  logic [CH_W-1:0] ch_reg;
  logic [CH_W-1:0] ch_next;
  logic temp_reg;
  logic temp_next;
  logic scanning;
  logic at_last;

  // Next position: after the last channel either a temperature slot or wrap.
  assign scanning = i_mode[1];
  assign at_last = (ch_reg >= i_last);
  assign ch_next = (!scanning || i_restart || temp_reg || at_last) ?
                   '0 : ch_reg + CH_W'(1);
  assign temp_next = scanning && !i_restart && !temp_reg && at_last &&
                     (i_mode == cfg_word_pkg::SEQ_SCAN_TEMP);

  // Position advances only at the end of each conversion.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ch_reg <= '0;
      temp_reg <= 1'b0;
    end else if (i_ce && i_step) begin
      ch_reg <= ch_next;
      temp_reg <= temp_next;
    end
  end

  assign o_channel = ch_reg;
  assign o_temp_slot = temp_reg;

  a_scan_wrap: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    i_ce && i_step && !i_restart && i_mode == 2'h3 && ch_reg == i_last
    |=> ch_reg == '0 && !temp_reg)
    else $error("Scan mode did not wrap to channel zero.");
  a_scan_temp: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    i_ce && i_step && !i_restart && i_mode == 2'h2 && ch_reg == i_last &&
    !temp_reg |=> temp_reg ##0 ch_reg == '0)
    else $error("Scan with temperature missed the temperature slot.");
endmodule // seq_stepper

// ### logic/cfg_word_decoder.sv
// Purpose: Receives and decodes the converter setup word.
// Assumes: i_eoc is a one-cycle end-of-conversion pulse on i_clk.
// Notes: Serial pins are synchronised; rising clock edges are sampled.
module cfg_word_decoder (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_cnv,
  input wire logic i_sck,
  input wire logic i_din,
  input wire logic i_eoc,
  output logic [13:0] o_setup_word,
  output logic o_bipolar,
  output logic o_differential,
  output logic o_com_ref,
  output logic o_temp_input,
  output logic [2:0] o_channel_select,
  output logic o_quarter_bw,
  output logic o_int_ref_en,
  output logic o_ext_ref_en,
  output logic o_ref_buffer_en,
  output logic o_temp_sensor_en,
  output logic o_ref_code_unused,
  output logic o_readback_en,
  output logic [2:0] o_conv_channel,
  output logic o_conv_temp
);
  localparam int unsigned W = cfg_word_pkg::WORD_W;

  logic [2:0] cnv_sync_reg;
  logic [2:0] sck_sync_reg;
  logic [1:0] din_sync_reg;
  logic cnv_s;
  logic sck_rise;
  logic frame_start;
  logic din_s;
  logic [W-1:0] shift_reg;
  logic [W-1:0] shift_next;
  logic [cfg_word_pkg::CNT_W-1:0] count_reg;
  logic [cfg_word_pkg::CNT_W-1:0] count_next;
  logic take_bit;
  logic word_done;
  logic pend_reg;
  logic [W-1:0] pend_word_reg;
  logic apply;
  logic [W-1:0] active_reg;
  logic [1:0] scan_reg;
  logic [1:0] scan_next;
  logic [2:0] pair;
  logic [2:0] ref_code;
  logic [1:0] seq_code;
  logic seq_ch_unused;
  logic seq_temp;
  logic [2:0] seq_ch;
  logic restart_scan;

  // Pin synchronisers; only the second stage onward is read.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnv_sync_reg <= 3'h7;
      sck_sync_reg <= 3'h0;
      din_sync_reg <= 2'h0;
    end else if (i_ce) begin
      cnv_sync_reg <= {cnv_sync_reg[1:0], i_cnv};
      sck_sync_reg <= {sck_sync_reg[1:0], i_sck};
      din_sync_reg <= {din_sync_reg[0], i_din};
    end
  end

  // Edge detection on the synchronised pins.
  assign cnv_s = cnv_sync_reg[1];
  assign din_s = din_sync_reg[1];
  assign sck_rise = sck_sync_reg[1] && !sck_sync_reg[2];
  assign frame_start = !cnv_s && cnv_sync_reg[2];

  // Bits are taken MSB first on the first 14 rising clocks of a frame.
  assign take_bit = sck_rise && !cnv_s &&
                    (count_reg < cfg_word_pkg::WORD_BITS);
  assign shift_next = {shift_reg[W-2:0], din_s};
  assign count_next = count_reg + 4'h1;
  assign word_done = take_bit && (count_next == cfg_word_pkg::WORD_BITS);

  // A word unfinished at conversion end or frame start is discarded.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      shift_reg <= '0;
      count_reg <= '0;
    end else if (i_ce) begin
      if (i_eoc || frame_start) begin
        count_reg <= '0;
      end else if (take_bit) begin
        shift_reg <= shift_next;
        count_reg <= count_next;
      end
    end
  end

  // A complete word waits here for the end of the conversion.
  // A word finishing on that same edge waits for the next one (set wins).
  assign apply = i_eoc && pend_reg;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pend_reg <= 1'b0;
      pend_word_reg <= '0;
    end else if (i_ce) begin
      if (word_done) begin
        pend_reg <= 1'b1;
        pend_word_reg <= shift_next;
      end else if (i_eoc) begin
        pend_reg <= 1'b0;
      end
    end
  end

  // Scan mode carried forward while the keep code is written.
  assign scan_next = (pend_word_reg[cfg_word_pkg::SEQ_HI:
                                    cfg_word_pkg::SEQ_LO] ==
                      cfg_word_pkg::SEQ_KEEP) ?
                     scan_reg :
                     pend_word_reg[cfg_word_pkg::SEQ_HI:
                                   cfg_word_pkg::SEQ_LO];

  // The word in force changes only at conversion end with bit 13 set.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      active_reg <= cfg_word_pkg::WORD_RESET;
      scan_reg <= cfg_word_pkg::SCAN_RESET;
    end else if (i_ce && apply &&
                 pend_word_reg[cfg_word_pkg::UPDATE_BIT]) begin
      active_reg <= pend_word_reg;
      scan_reg <= scan_next;
    end
  end

  // Field decode of the word in force.
  assign pair = active_reg[cfg_word_pkg::PAIR_HI:cfg_word_pkg::PAIR_LO];
  assign ref_code = active_reg[cfg_word_pkg::REF_HI:cfg_word_pkg::REF_LO];
  assign seq_code = active_reg[cfg_word_pkg::SEQ_HI:cfg_word_pkg::SEQ_LO];
  assign o_setup_word = active_reg;
  assign o_bipolar = !pair[2] && !o_temp_input;
  assign o_differential = !pair[1];
  assign o_com_ref = (pair == 3'h2) ||
                     (pair == cfg_word_pkg::PAIR_SE_COM_GND);
  assign o_temp_input = (pair == cfg_word_pkg::PAIR_TEMP);
  assign o_channel_select = active_reg[cfg_word_pkg::CHAN_HI:
                                       cfg_word_pkg::CHAN_LO];
  assign o_quarter_bw = !active_reg[cfg_word_pkg::BW_BIT];
  assign o_readback_en = !active_reg[cfg_word_pkg::READBACK_BIT];

  // Reference source, buffer and temperature sensor power.
  assign o_int_ref_en = (ref_code == cfg_word_pkg::REF_INTERNAL);
  assign o_ext_ref_en = (ref_code == cfg_word_pkg::REF_EXT_SENSOR) ||
                        (ref_code == cfg_word_pkg::REF_BUF_SENSOR) ||
                        (ref_code == cfg_word_pkg::REF_EXT_QUIET) ||
                        (ref_code == cfg_word_pkg::REF_BUF_QUIET);
  assign o_ref_buffer_en = (ref_code == cfg_word_pkg::REF_BUF_SENSOR) ||
                           (ref_code == cfg_word_pkg::REF_BUF_QUIET);
  assign o_temp_sensor_en = o_int_ref_en ||
                            (ref_code == cfg_word_pkg::REF_EXT_SENSOR) ||
                            (ref_code == cfg_word_pkg::REF_BUF_SENSOR);
  assign o_ref_code_unused = (ref_code == 3'h0) ||
                             (ref_code == 3'h4) ||
                             (ref_code == 3'h5);

  // Channel sequencer; a new scan restarts at channel 0.
  assign restart_scan = apply && pend_word_reg[cfg_word_pkg::UPDATE_BIT] &&
                        (scan_next != scan_reg);
  seq_stepper #(
    .CH_W(3)
  ) u_stepper (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_step(i_eoc),
    .i_restart(restart_scan),
    .i_mode(scan_reg),
    .i_last(o_channel_select),
    .o_channel(seq_ch),
    .o_temp_slot(seq_temp)
  );

  // Conversion target follows the sequencer only while it scans.
  assign seq_ch_unused = (scan_reg == cfg_word_pkg::SEQ_OFF);
  assign o_conv_channel = seq_ch_unused ? o_channel_select : seq_ch;
  assign o_conv_temp = o_temp_input ||
                       (!seq_ch_unused && seq_temp);

  sequence s_word_ready;
    pend_reg && pend_word_reg[13];
  endsequence
  sequence s_end_conv;
    i_ce && i_eoc;
  endsequence

  a_word_apply: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    s_word_ready ##0 s_end_conv |=> active_reg == $past(pend_word_reg))
    else $error("Complete word was not applied at conversion end.");
  a_update_gate: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    pend_reg && !pend_word_reg[13] |=> $stable(active_reg))
    else $error("Word without update bit changed the setup.");
  a_hold_midconv: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    !i_eoc |=> $stable(active_reg))
    else $error("Setup changed outside conversion end.");
  a_bit_count: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    i_ce && take_bit && !i_eoc && !frame_start
    |=> count_reg == $past(count_reg) + 4'h1 && shift_reg[0] == $past(din_s))
    else $error("Serial bit not counted or shifted.");
  a_word_pending: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    i_ce && word_done |=> pend_reg && pend_word_reg == $past(shift_next))
    else $error("Fourteenth bit did not complete the word.");
  a_sensor_power: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    active_reg[5:3] == 3'h1
    |-> o_int_ref_en && o_temp_sensor_en && !o_ext_ref_en)
    else $error("Internal reference on without temperature sensor.");
  a_quarter_bw: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    s_word_ready ##0 s_end_conv
    |=> o_quarter_bw == !$past(pend_word_reg[6]))
    else $error("Bandwidth decode inverted.");
  a_readback_sel: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    s_word_ready ##0 s_end_conv
    |=> o_readback_en == !$past(pend_word_reg[0]))
    else $error("Readback enable decode wrong.");
  a_temp_pairing: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    active_reg[12:10] == 3'h3 |-> o_conv_temp && !o_bipolar)
    else $error("Temperature pairing code not routed.");
  a_sensor_off: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    active_reg[5:4] == 2'h3 |-> !o_temp_sensor_en && o_ext_ref_en)
    else $error("Sensor on with quiet external reference.");
endmodule // cfg_word_decoder

// ### bench/host_link_model.sv
// Purpose: Serial host that shifts setup words into the decoder.
// Assumes: Called at a falling clock edge; sck idles low.
// Notes: Data line shows the inverse of its last bit when released.
module host_link_model (
  input wire logic i_clk,
  output logic o_cnv,
  output logic o_sck,
  output logic o_din
);
  timeunit 1ns;
  timeprecision 1ps;
  // Link rests with the frame closed and the clock still.
  initial begin
    o_cnv = 1'b1;
    o_sck = 1'b0;
    o_din = 1'b1;
  end
  // Sends the top n bits of w; each phase lasts four cycles.
  task automatic send(input logic [13:0] w, input int n);
    o_cnv = 1'b0;
    repeat (4) @(negedge i_clk);
    for (int k = 13; k > 13 - n; k--) begin
      o_din = w[k];
      repeat (4) @(negedge i_clk);
      o_sck = 1'b1;
      repeat (4) @(negedge i_clk);
      o_sck = 1'b0;
    end
    repeat (4) @(negedge i_clk);
    o_cnv = 1'b1;
    o_din = ~o_din; // Released line must not hold its value.
    repeat (4) @(negedge i_clk);
  endtask
endmodule // host_link_model

// ### bench/cfg_word_decoder_tb.sv
// Purpose: Self-checking bench for the setup word decoder.
// Assumes: Host never writes unused reference codes.
// Notes: Inputs change at the falling clock edge.
module cfg_word_decoder_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_ce = 1'b1;
  logic i_eoc = 1'b0;
  logic cnv, sck, din, bip, dif, com, tin, qbw, iref, eref, rbuf, tsen;
  logic unused, rben, ctemp;
  logic [13:0] word;
  logic [2:0] csel, cch;
  int fail_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  // Clock at 125 MHz.
  always #4 i_clk = ~i_clk;
  host_link_model i_host_link_model (.i_clk(i_clk), .o_cnv(cnv),
    .o_sck(sck), .o_din(din));
  cfg_word_decoder i_cfg_word_decoder (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_ce(i_ce), .i_cnv(cnv), .i_sck(sck), .i_din(din), .i_eoc(i_eoc),
    .o_setup_word(word), .o_bipolar(bip), .o_differential(dif),
    .o_com_ref(com), .o_temp_input(tin), .o_channel_select(csel),
    .o_quarter_bw(qbw), .o_int_ref_en(iref), .o_ext_ref_en(eref),
    .o_ref_buffer_en(rbuf), .o_temp_sensor_en(tsen),
    .o_ref_code_unused(unused), .o_readback_en(rben),
    .o_conv_channel(cch), .o_conv_temp(ctemp));
  // Prints the counts and the verdict, then stops.
  task automatic give_verdict();
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Compares one value and counts the outcome.
  task automatic check(input logic [13:0] got, input logic [13:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Pulses end of conversion once and lets the outputs settle.
  task automatic eoc();
    i_eoc = 1'b1;
    @(negedge i_clk);
    i_eoc = 1'b0;
    repeat (2) @(negedge i_clk);
  endtask
  // Writes a whole word and ends the conversion.
  task automatic wr(input logic [13:0] w);
    i_host_link_model.send(w, 14);
    eoc();
  endtask
  // Reset value, then the two all-ones power-up conversions.
  task automatic t_reset();
    check(word, 14'h3fff);
    wr(14'h3fff);
    wr(14'h3fff);
    check(word, 14'h3fff);
    $display("test reset done");
  endtask
  // Every pairing code, with channel, bandwidth and readback varied.
  task automatic t_pairing();
    logic [2:0] pe [8];
    logic [2:0] c;
    pe = '{3'h6, 3'h6, 3'h5, 3'h0, 3'h2, 3'h2, 3'h1, 3'h0};
    for (int k = 0; k < 8; k++) begin
      c = 3'(k);
      wr({1'b1, c, c, c[0], 3'h7, 2'h0, c[1]});
      if (k != 3) check(14'({bip, dif, com}), 14'(pe[k]));
      check(14'({tin, ctemp}), (k == 3) ? 14'h3 : 14'h0);
      check(14'(csel), 14'(c));
      check(14'(cch), 14'(c));
      check(14'(qbw), 14'(!c[0]));
      check(14'(rben), 14'(!c[1]));
    end
    $display("test pairing done");
  endtask
  // Every usable reference code; unused ones are never written.
  task automatic t_ref();
    logic [3:0] re [8];
    re = '{4'h0, 4'h9, 4'h5, 4'h7, 4'h0, 4'h0, 4'h4, 4'h6};
    for (int k = 1; k < 8; k++) begin
      if (k == 4 || k == 5) continue;
      wr({1'b1, 3'h7, 3'h0, 1'b1, 3'(k), 2'h0, 1'b1});
      check(14'({iref, eref, rbuf, tsen}), 14'(re[k]));
      check(14'(unused), 14'h0);
    end
    $display("test reference done");
  endtask
  // Update gating, late application, frozen enable, partial word.
  task automatic t_hold();
    logic [13:0] w0;
    w0 = word;
    wr(14'h1555);
    check(word, w0);
    i_host_link_model.send(14'h2ab1, 14);
    check(word, w0);
    i_ce = 1'b0;
    eoc();
    i_ce = 1'b1;
    @(negedge i_clk);
    check(word, w0);
    eoc();
    check(word, 14'h2ab1);
    i_host_link_model.send(14'h3fff, 10);
    eoc();
    check(word, 14'h2ab1);
    $display("test hold done");
  endtask
  // Scan with temperature slot, plain wrap, and update during scan.
  task automatic t_seq();
    logic [3:0] sq [4];
    sq = '{4'h0, 4'h1, 4'h8, 4'h0};
    wr({1'b1, 3'h7, 3'h1, 1'b1, 3'h7, 2'h2, 1'b1});
    for (int k = 0; k < 4; k++) begin
      if (k > 0) eoc();
      check(14'({ctemp, cch}), 14'(sq[k]));
    end
    wr({1'b1, 3'h7, 3'h1, 1'b1, 3'h7, 2'h3, 1'b1});
    check(14'({ctemp, cch}), 14'h0);
    eoc();
    check(14'({ctemp, cch}), 14'h1);
    wr({1'b1, 3'h7, 3'h1, 1'b1, 3'h7, 2'h1, 1'b1});
    check(14'({ctemp, cch}), 14'h0);
    $display("test sequencer done");
  endtask
  // Cuts a hang short.
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      give_verdict();
    end
  end
  // Main sequence; eoc spacing stays slow enough for quarter bw.
  initial begin
    repeat (6) @(negedge i_clk);
    i_rst_n = 1'b1;
    @(negedge i_clk);
    t_reset();
    t_pairing();
    t_ref();
    t_hold();
    t_seq();
    give_verdict();
  end
endmodule // cfg_word_decoder_tb
